// *** trig_qual.sv ***
// Purpose: Pattern, runt, transition-time and timeout trigger qualification
// Assumes: Comparator outputs are asynchronous levels; one 250 MHz clock
// Notes: All times are cycle counts of REF_CLK_I; a timeout time of zero never fires
// Overview of operation
// [R1] Each channel holds required high, required low or don't-care.
// [R2] Pattern has one position per analog channel plus sixteen logic channels if fitted.
// [R3] AND mode: every cared channel must match its required state.
// [R4] OR mode: at least one cared channel matches its required state.
// [R5] Duration switch selects level-duration evaluation and enables time limitation.
// [R6] Duration on: fire when condition stays true, or false, for programmed time.
// [R7] Duration off: fire when condition goes true, or goes false.
// [R8] Timeout mode: fire once the match has lasted the minimum time.
// [R9] Greater or less mode: fire when condition ends after, or before, reference.
// [R10] Equal mode: fire when duration is within lower limit plus or minus variation.
// [R11] Unequal mode: fire when duration is outside lower limit plus or minus variation.
// [R12] Inside mode: fire when duration lies between lower and upper limits.
// [R13] Outside mode: fire when duration is below lower or above upper limit.
// [R14] Runt: first threshold crossed twice without crossing the second in between.
// [R15] Negative runt uses upper threshold twice; positive runt uses lower twice.
// [R16] Runt polarity selects positive, negative or both by first slope.
// [R17] Transition timing starts at first threshold and stops at second.
// [R18] Slope setting selects rising, falling or both edges.
// [R19] Greater or lower mode fires on transitions longer, or shorter, than reference.
// [R20] Equal or not-equal fires inside, or outside, reference plus or minus variation.
// [R21] Timeout fires when the source does not cross its threshold for full time.
// [R22] Timeout range selects staying above or staying below the threshold.
// [R23] Inputs synchronised, times held as cycle counts, counters restart on change.
`include "trig_qual_regs.svh"

module trig_qual #(
  parameter int N_ANA = 4,
  parameter bit MSO_FITTED = 1'b1
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Comparator levels
  input wire logic [N_ANA-1:0] CMP_ANA_I,
  input wire logic [15:0] CMP_LOGIC_I,
  input wire logic ABOVE_UPPER_I,
  input wire logic ABOVE_LOWER_I,
  input wire logic ABOVE_TMO_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Trigger pulses
  output logic PAT_TRIG_O,
  output logic RUNT_TRIG_O,
  output logic SLEW_TRIG_O,
  output logic TMO_TRIG_O,
  output logic TRIG_O
);

  localparam int PW = N_ANA + (MSO_FITTED ? `LOGIC_CHANNELS : 0);
  localparam logic [19:0] VALID = 20'((21'h1 << PW) - 21'h1);

  // Only two or four analog channels are served
  if (!(N_ANA == 2 || N_ANA == 4)) begin : g_bad_chans
    $error("N_ANA must be 2 or 4");
  end

  trig_qual_pkg::state_type q, d;
  logic [19:0] pat_raw;
  logic [19:0] chan_ok;

  assign pat_raw = MSO_FITTED ? 20'({CMP_LOGIC_I, CMP_ANA_I}) : 20'(CMP_ANA_I);

  // Per-channel match: don't-care positions count as matched in AND, not in OR
  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_chan
      assign chan_ok[gi] = ~(q.pat_s2[gi] ^ q.pat_level[gi]); // see [R1]
    end
  endgenerate

  function automatic logic width_ok(input logic [2:0] m, input logic [31:0] len, input logic [31:0] lo_t,
                                    input logic [31:0] up_t, input logic [31:0] dv);
    logic [32:0] lo;
    logic [32:0] hi;
    logic [32:0] l33;
    logic r;
    lo = (lo_t > dv) ? {1'b0, lo_t - dv} : 33'h0;
    hi = {1'b0, lo_t} + {1'b0, dv};
    l33 = {1'b0, len};
    case (trig_qual_pkg::pat_mode_type'(m))
      trig_qual_pkg::PM_GREATER: r = len > lo_t; // see [R9] [R19]
      trig_qual_pkg::PM_LESS: r = len < lo_t; // see [R9] [R19]
      trig_qual_pkg::PM_EQUAL: r = (l33 >= lo) && (l33 <= hi); // see [R10] [R20]
      trig_qual_pkg::PM_UNEQUAL: r = (l33 < lo) || (l33 > hi); // see [R11] [R20]
      trig_qual_pkg::PM_INSIDE: r = (len > lo_t) && (len < up_t); // see [R12]
      trig_qual_pkg::PM_OUTSIDE: r = (len < lo_t) || (len > up_t); // see [R13]
      default: r = 1'b0;
    endcase
    return r;
  endfunction : width_ok

  logic cond_and, cond_or, pat_qual, pat_ev;
  logic up, lo, up_rose, up_fell, lo_rose, lo_fell, tmo_qual;
  logic rise_ok, fall_ok, pos_runt, neg_runt, slew_done;
  logic [31:0] slew_len;
  logic [2:0] slew_mode;
  logic [3:0] ev;
  logic sel_ev;

  always_comb begin
    d = q;
    slew_done = 1'b0;
    slew_len = 32'h0;
    pos_runt = 1'b0;
    neg_runt = 1'b0;
    // Two-stage synchronisers
    d.pat_s1 = pat_raw & VALID; // see [R2] [R23]
    d.pat_s2 = q.pat_s1;
    d.lvl_s1 = {ABOVE_TMO_I, ABOVE_LOWER_I, ABOVE_UPPER_I}; // see [R23]
    d.lvl_s2 = q.lvl_s1;
    d.lvl_prev = q.lvl_s2;

    // Pattern condition
    cond_and = &(chan_ok | ~(q.pat_care & VALID)); // see [R3]
    cond_or = |(chan_ok & q.pat_care & VALID); // see [R4]
    d.pat_cond = q.ctrl.comb_or ? cond_or : cond_and;
    pat_qual = q.ctrl.pat_false ? ~q.pat_cond : q.pat_cond; // see [R6] [R7]
    d.pat_qual_prev = pat_qual;
    if (!pat_qual) begin
      d.run_cnt = 32'h0; // see [R23]
    end else if (q.run_cnt != 32'hFFFF_FFFF) begin
      d.run_cnt = q.run_cnt + 32'h1;
    end
    if (!q.ctrl.dur_on) begin
      pat_ev = pat_qual & ~q.pat_qual_prev; // see [R5] [R7]
    end else if (q.ctrl.pmode == trig_qual_pkg::PM_TIMEOUT) begin
      pat_ev = pat_qual && (d.run_cnt == q.lower_lim) && (q.run_cnt != q.lower_lim); // see [R5] [R6] [R8]
    end else begin
      pat_ev = ~pat_qual & q.pat_qual_prev &
               width_ok(q.ctrl.pmode, q.run_cnt, q.lower_lim, q.upper_lim, q.variation); // see [R9]
    end

    // Dual-threshold edges
    up = q.lvl_s2[0];
    lo = q.lvl_s2[1];
    up_rose = up & ~q.lvl_prev[0];
    up_fell = ~up & q.lvl_prev[0];
    lo_rose = lo & ~q.lvl_prev[1];
    lo_fell = ~lo & q.lvl_prev[1];

    // Runt: first threshold twice without the second in between
    if (lo_fell && q.pos_arm) begin
      pos_runt = 1'b1; // see [R14] [R15]
    end
    if (up_rose && q.neg_arm) begin
      neg_runt = 1'b1; // see [R14] [R15]
    end
    d.pos_arm = (q.pos_arm | (lo_rose & ~up)) & ~up_rose & ~lo_fell;
    d.neg_arm = (q.neg_arm | (up_fell & lo)) & ~lo_fell & ~up_rose;

    // Transition time
    rise_ok = q.ctrl.slope != trig_qual_pkg::SL_FALL; // see [R18]
    fall_ok = q.ctrl.slope != trig_qual_pkg::SL_RISE;
    case (q.sstate)
      trig_qual_pkg::SS_IDLE: begin
        d.slew_cnt = 32'h1;
        if (rise_ok && lo_rose) begin
          if (up_rose) begin
            slew_done = 1'b1;
          end else begin
            d.sstate = trig_qual_pkg::SS_RISING; // see [R17]
          end
        end else if (fall_ok && up_fell) begin
          if (lo_fell) begin
            slew_done = 1'b1;
          end else begin
            d.sstate = trig_qual_pkg::SS_FALLING; // see [R17]
          end
        end
      end
      trig_qual_pkg::SS_RISING: begin
        d.slew_cnt = (q.slew_cnt == 32'hFFFF_FFFF) ? q.slew_cnt : q.slew_cnt + 32'h1;
        if (up_rose) begin
          slew_done = 1'b1; // see [R17]
          slew_len = q.slew_cnt;
          d.sstate = trig_qual_pkg::SS_IDLE;
        end else if (lo_fell) begin
          d.sstate = trig_qual_pkg::SS_IDLE;
        end
      end
      trig_qual_pkg::SS_FALLING: begin
        d.slew_cnt = (q.slew_cnt == 32'hFFFF_FFFF) ? q.slew_cnt : q.slew_cnt + 32'h1;
        if (lo_fell) begin
          slew_done = 1'b1; // see [R17]
          slew_len = q.slew_cnt;
          d.sstate = trig_qual_pkg::SS_IDLE;
        end else if (up_rose) begin
          d.sstate = trig_qual_pkg::SS_IDLE;
        end
      end
      default: begin
        d.sstate = trig_qual_pkg::SS_IDLE;
      end
    endcase
    slew_mode = {1'b0, q.ctrl.scmp} + 3'h1;

    // Timeout: count while the level stays on the chosen side
    tmo_qual = q.ctrl.tmo_high ? q.lvl_s2[2] : ~q.lvl_s2[2]; // see [R22]
    if (!tmo_qual || (q.lvl_s2[2] != q.lvl_prev[2])) begin
      d.tmo_cnt = 32'h0; // see [R23]
    end else if (q.tmo_cnt != 32'hFFFF_FFFF) begin
      d.tmo_cnt = q.tmo_cnt + 32'h1;
    end

    ev[0] = pat_ev;
    ev[1] = (pos_runt && q.ctrl.rpol != trig_qual_pkg::POL_NEG) ||
            (neg_runt && q.ctrl.rpol != trig_qual_pkg::POL_POS); // see [R16]
    ev[2] = slew_done && width_ok(slew_mode, slew_len, q.slew_ref, 32'h0, q.slew_var); // see [R19] [R20]
    ev[3] = tmo_qual && (d.tmo_cnt == q.tmo_time) && (q.tmo_cnt != q.tmo_time); // see [R21]
    sel_ev = ev[q.ctrl.kind];
    d.pat_trig = ev[0];
    d.runt_trig = ev[1];
    d.slew_trig = ev[2];
    d.tmo_trig = ev[3];
    d.trig = sel_ev;
    if (sel_ev) begin
      d.trig_count = q.trig_count + 32'h1;
    end

    // Register writes; a new event outranks a status clear in the same cycle, not a count clear
    if (WR_I) begin
      case (ADDR_I)
        `OFS_CTRL: d.ctrl = trig_qual_pkg::ctrl_type'(WDATA_I[`CTRL_WIDTH-1:0]);
        `OFS_PAT_LEVEL: d.pat_level = WDATA_I[19:0] & VALID; // see [R1]
        `OFS_PAT_CARE: d.pat_care = WDATA_I[19:0] & VALID; // see [R1]
        `OFS_LOWER_LIM: d.lower_lim = WDATA_I; // see [R23]
        `OFS_UPPER_LIM: d.upper_lim = WDATA_I;
        `OFS_VARIATION: d.variation = WDATA_I;
        `OFS_SLEW_REF: d.slew_ref = WDATA_I;
        `OFS_SLEW_VAR: d.slew_var = WDATA_I;
        `OFS_TMO_TIME: d.tmo_time = WDATA_I;
        `OFS_STATUS: d.seen = q.seen & ~WDATA_I[3:0];
        `OFS_TRIG_COUNT: d.trig_count = 32'h0;
        default: begin
        end
      endcase
    end
    d.seen = d.seen | ev;

    // Register reads answer in the next cycle only
    d.rdata = 32'h0;
    if (RD_I) begin
      case (ADDR_I)
        `OFS_CTRL: d.rdata = 32'(q.ctrl);
        `OFS_PAT_LEVEL: d.rdata = 32'(q.pat_level);
        `OFS_PAT_CARE: d.rdata = 32'(q.pat_care);
        `OFS_LOWER_LIM: d.rdata = q.lower_lim;
        `OFS_UPPER_LIM: d.rdata = q.upper_lim;
        `OFS_VARIATION: d.rdata = q.variation;
        `OFS_SLEW_REF: d.rdata = q.slew_ref;
        `OFS_SLEW_VAR: d.rdata = q.slew_var;
        `OFS_TMO_TIME: d.rdata = q.tmo_time;
        `OFS_STATUS: d.rdata = {26'h0, q.sstate != trig_qual_pkg::SS_IDLE, q.pat_cond, q.seen};
        `OFS_TRIG_COUNT: d.rdata = q.trig_count;
        default: d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      q <= '0;
      q.ctrl <= trig_qual_pkg::ctrl_type'(`CTRL_RESET);
      q.lower_lim <= `TIME_RESET;
      q.upper_lim <= `TIME_RESET;
      q.slew_ref <= `TIME_RESET;
      q.tmo_time <= `TIME_RESET;
      q.sstate <= trig_qual_pkg::SS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign RDATA_O = q.rdata;
  assign PAT_TRIG_O = q.pat_trig;
  assign RUNT_TRIG_O = q.runt_trig;
  assign SLEW_TRIG_O = q.slew_trig;
  assign TMO_TRIG_O = q.tmo_trig;
  assign TRIG_O = q.trig;

  a_sync_two_stage: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R23]
    $past(RST_I, 2) == 1'b0 |-> q.pat_s2 == ($past(pat_raw, 2) & VALID))
    else $error("pattern input not delayed by two stages");

  a_and_combine: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R3]
    !$past(RST_I) && !q.ctrl.comb_or && $stable(q.ctrl) && $stable(q.pat_level) && $stable(q.pat_care) |->
    q.pat_cond == &(~($past(q.pat_s2) ^ q.pat_level) | ~q.pat_care))
    else $error("AND pattern condition wrong");

  a_or_combine: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R4]
    !$past(RST_I) && q.ctrl.comb_or && $stable(q.ctrl) && $stable(q.pat_level) && $stable(q.pat_care) |->
    q.pat_cond == |(~($past(q.pat_s2) ^ q.pat_level) & q.pat_care))
    else $error("OR pattern condition wrong");

  a_edge_mode: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R7]
    PAT_TRIG_O && !$past(q.ctrl.dur_on) |->
    $past(q.pat_cond ^ q.ctrl.pat_false) && !$past(q.pat_qual_prev))
    else $error("edge pattern trigger without transition");

  a_timeout_reach: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R8]
    PAT_TRIG_O && $past(q.ctrl.dur_on) && $past(q.ctrl.pmode) == trig_qual_pkg::PM_TIMEOUT |->
    $past(q.run_cnt) + 32'h1 == $past(q.lower_lim))
    else $error("pattern timeout fired at wrong count");

  a_run_restart: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R23]
    !(q.pat_cond ^ q.ctrl.pat_false) |=> q.run_cnt == 32'h0)
    else $error("duration counter did not restart");

  a_runt_armed: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R14]
    RUNT_TRIG_O |-> $past(q.pos_arm) || $past(q.neg_arm))
    else $error("runt flagged without arming crossing");

  a_slew_active: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R17]
    SLEW_TRIG_O && $past(q.sstate) == trig_qual_pkg::SS_IDLE |-> $past(q.lvl_s2[1] ^ q.lvl_prev[1]))
    else $error("transition trigger without measurement");

  a_tmo_reach: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R21]
    TMO_TRIG_O |-> $past(q.tmo_cnt) + 32'h1 == $past(q.tmo_time))
    else $error("timeout fired at wrong count");

  a_read_window: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    RDATA_O != 32'h0 |-> $past(RD_I))
    else $error("read data outside its cycle");

  a_edge_once: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R7]
    PAT_TRIG_O && !$past(q.ctrl.dur_on) && $stable(q.ctrl) |=> !PAT_TRIG_O)
    else $error("edge trigger repeated");

  a_width_end: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R9]
    PAT_TRIG_O && $past(q.ctrl.dur_on) && $past(q.ctrl.pmode) != trig_qual_pkg::PM_TIMEOUT |->
    !$past(q.pat_cond ^ q.ctrl.pat_false) && $past(q.pat_qual_prev))
    else $error("width trigger before period end");

  a_equal_window: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R10]
    PAT_TRIG_O && $past(q.ctrl.dur_on) && $past(q.ctrl.pmode) == trig_qual_pkg::PM_EQUAL |->
    33'($past(q.run_cnt)) + 33'($past(q.variation)) >= 33'($past(q.lower_lim)) &&
    33'($past(q.run_cnt)) <= 33'($past(q.lower_lim)) + 33'($past(q.variation)))
    else $error("equal width trigger outside window");

  a_inside_window: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R12]
    PAT_TRIG_O && $past(q.ctrl.dur_on) && $past(q.ctrl.pmode) == trig_qual_pkg::PM_INSIDE |->
    $past(q.run_cnt) > $past(q.lower_lim) && $past(q.run_cnt) < $past(q.upper_lim))
    else $error("inside trigger outside limits");

  a_runt_pos: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R15] [R16]
    RUNT_TRIG_O && $past(q.ctrl.rpol) == trig_qual_pkg::POL_POS |-> $past(q.pos_arm && !q.lvl_s2[1]))
    else $error("positive runt without lower return");

  a_runt_neg: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R15] [R16]
    RUNT_TRIG_O && $past(q.ctrl.rpol) == trig_qual_pkg::POL_NEG |-> $past(q.neg_arm && q.lvl_s2[0]))
    else $error("negative runt without upper return");

  a_rise_entry: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R18]
    $changed(q.sstate) && q.sstate == trig_qual_pkg::SS_RISING |-> $past(q.ctrl.slope) != trig_qual_pkg::SL_FALL)
    else $error("rise measured with fall slope");

  a_fall_entry: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R18]
    $changed(q.sstate) && q.sstate == trig_qual_pkg::SS_FALLING |-> $past(q.ctrl.slope) != trig_qual_pkg::SL_RISE)
    else $error("fall measured with rise slope");

  a_tmo_side: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see [R22]
    TMO_TRIG_O |-> $past(q.lvl_s2[2]) == $past(q.ctrl.tmo_high))
    else $error("timeout fired on wrong side");

endmodule : trig_qual

// *** trig_qual_regs.svh ***
// Purpose: Register offsets, reset values and constants of the trigger qualifier
// Assumes: Word-aligned byte addresses on an 8-bit register address
// Notes: Fields of the control word follow pkg ctrl_type order
`ifndef TRIG_QUAL_REGS_SVH
`define TRIG_QUAL_REGS_SVH

`define OFS_CTRL       8'h00
`define OFS_PAT_LEVEL  8'h04
`define OFS_PAT_CARE   8'h08
`define OFS_LOWER_LIM  8'h0C
`define OFS_UPPER_LIM  8'h10
`define OFS_VARIATION  8'h14
`define OFS_SLEW_REF   8'h18
`define OFS_SLEW_VAR   8'h1C
`define OFS_TMO_TIME   8'h20
`define OFS_STATUS     8'h24
`define OFS_TRIG_COUNT 8'h28

`define CTRL_WIDTH     15
`define CTRL_RESET     15'h0000
`define PAT_WIDTH_MAX  20
`define LOGIC_CHANNELS 16
`define TIME_RESET     32'h0000_0001
`define STATUS_SEEN_LO 0
`define STATUS_COND    4
`define STATUS_BUSY    5

`endif

// *** trig_qual_pkg.sv ***
// Purpose: Types shared by the trigger qualifier
// Assumes: Control word is 15 bits, pattern at most 20 positions
// Notes: First declared field of a packed struct is its most significant
package trig_qual_pkg;

  typedef enum logic [1:0] {
    TT_PATTERN = 2'h0,
    TT_RUNT = 2'h1,
    TT_SLEW = 2'h2,
    TT_TIMEOUT = 2'h3
  } trig_kind_type;

  typedef enum logic [2:0] {
    PM_TIMEOUT = 3'h0,
    PM_GREATER = 3'h1,
    PM_LESS = 3'h2,
    PM_EQUAL = 3'h3,
    PM_UNEQUAL = 3'h4,
    PM_INSIDE = 3'h5,
    PM_OUTSIDE = 3'h6
  } pat_mode_type;

  typedef enum logic [1:0] {
    POL_POS = 2'h0,
    POL_NEG = 2'h1,
    POL_BOTH = 2'h2
  } runt_pol_type;

  typedef enum logic [1:0] {
    SL_RISE = 2'h0,
    SL_FALL = 2'h1,
    SL_EITHER = 2'h2
  } slope_type;

  typedef enum logic [1:0] {
    SC_GREATER = 2'h0,
    SC_LESS = 2'h1,
    SC_EQUAL = 2'h2,
    SC_UNEQUAL = 2'h3
  } slew_cmp_type;

  typedef enum logic [1:0] {
    SS_IDLE = 2'h0,
    SS_RISING = 2'h1,
    SS_FALLING = 2'h2
  } slew_state_type;

  typedef struct packed {
    logic tmo_high;
    slew_cmp_type scmp;
    slope_type slope;
    runt_pol_type rpol;
    pat_mode_type pmode;
    logic pat_false;
    logic dur_on;
    logic comb_or;
    trig_kind_type kind;
  } ctrl_type;

  typedef struct packed {
    logic [19:0] pat_s1;
    logic [19:0] pat_s2;
    logic [2:0] lvl_s1;
    logic [2:0] lvl_s2;
    logic [2:0] lvl_prev;
    ctrl_type ctrl;
    logic [19:0] pat_level;
    logic [19:0] pat_care;
    logic [31:0] lower_lim;
    logic [31:0] upper_lim;
    logic [31:0] variation;
    logic [31:0] slew_ref;
    logic [31:0] slew_var;
    logic [31:0] tmo_time;
    logic pat_cond;
    logic pat_qual_prev;
    logic [31:0] run_cnt;
    logic pos_arm;
    logic neg_arm;
    slew_state_type sstate;
    logic [31:0] slew_cnt;
    logic [31:0] tmo_cnt;
    logic [3:0] seen;
    logic [31:0] trig_count;
    logic pat_trig;
    logic runt_trig;
    logic slew_trig;
    logic tmo_trig;
    logic trig;
    logic [31:0] rdata;
  } state_type;

endpackage : trig_qual_pkg

// *** front_cmp.sv ***
// Purpose: Threshold comparators standing in front of the trigger qualifier
// Assumes: Levels in millivolts; ideal comparators without hysteresis
// Notes: Outputs follow the level at once, like the real comparators
module front_cmp #(
  parameter int UPPER_MV = 200,
  parameter int LOWER_MV = 100,
  parameter int TMO_MV = 150
) (
  // Levels
  input wire logic [19:0] pat_i,
  input wire logic [15:0] pulse_mv_i,
  input wire logic [15:0] tmo_mv_i,
  // Comparator outputs
  output logic [3:0] ana_o,
  output logic [15:0] logic_o,
  output logic above_upper_o,
  output logic above_lower_o,
  output logic above_tmo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign ana_o = pat_i[3:0];
  assign logic_o = pat_i[19:4];
  assign above_upper_o = int'(pulse_mv_i) > UPPER_MV;
  assign above_lower_o = int'(pulse_mv_i) > LOWER_MV;
  assign above_tmo_o = int'(tmo_mv_i) > TMO_MV;
endmodule : front_cmp

// *** trig_qual_tb.sv ***
// Purpose: Self-checking bench for the trigger qualifier
// Assumes: Four analog channels with the logic channels fitted
// Notes: Trigger pulses are counted over a window and compared with expected counts
`include "trig_qual_regs.svh"
module trig_qual_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LO = 4;
  localparam int UP = 9;
  localparam int VAR = 3;
  localparam int SREF = 5;
  localparam int SVAR = 2;
  localparam logic [15:0] HI_MV = 16'h012C;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [19:0] pat = 20'h00000;
  logic [15:0] pulse_mv = 16'h0000;
  logic [15:0] tmo_mv = 16'h012C;
  logic [3:0] ana;
  logic [15:0] lgc;
  logic up_c;
  logic lo_c;
  logic tmo_c;
  logic [31:0] rdata;
  logic pat_t;
  logic runt_t;
  logic slew_t;
  logic tmo_t;
  logic trig;
  wire [3:0] types = {tmo_t, slew_t, runt_t, pat_t};
  trig_qual_pkg::ctrl_type cw;
  int miscompares = 0;
  int checked = 0;
  int n_type = 0;
  int n_trig = 0;
  int sel = 0;
  int total = 0;
  logic counting = 1'b0;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40};
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
  logic [6:0] e_or = 7'b1011000;
  logic [6:0] e_f = 7'b1100000;
  logic [6:0] e_x = 7'b1101011;
  logic [19:0] e_a [7] = '{20'h00000, 20'h00000, 20'h00000, 20'h00002, 20'h00002, 20'h00011, 20'h00010};
  logic [19:0] e_b [7] = '{20'h00011, 20'hFFFF1, 20'h00001, 20'h00010, 20'hFFEE2, 20'h00000, 20'h00002};
  int wl [3] = '{2, 6, 12};
  int rt [3] = '{50, 17, 10};
  int sl [3] = '{2, 6, 10};
  logic [15:0] w_s [3] = '{16'h0000, 16'h012C, 16'h0000};
  logic [15:0] w_m [3] = '{16'h0096, 16'h0096, 16'h012C};

  front_cmp u_front (.pat_i(pat), .pulse_mv_i(pulse_mv), .tmo_mv_i(tmo_mv), .ana_o(ana), .logic_o(lgc),
    .above_upper_o(up_c), .above_lower_o(lo_c), .above_tmo_o(tmo_c));
  trig_qual #(.N_ANA(4), .MSO_FITTED(1'b1)) u_dut (.REF_CLK_I(ref_clk), .RST_I(rst), .CMP_ANA_I(ana),
    .CMP_LOGIC_I(lgc), .ABOVE_UPPER_I(up_c), .ABOVE_LOWER_I(lo_c), .ABOVE_TMO_I(tmo_c), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PAT_TRIG_O(pat_t), .RUNT_TRIG_O(runt_t),
    .SLEW_TRIG_O(slew_t), .TMO_TRIG_O(tmo_t), .TRIG_O(trig));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (counting && types[sel] !== 1'b0) n_type++;
    if (counting && trig !== 1'b0) n_trig++;
  end

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    checked++;
    if (rdata !== exp) begin
      miscompares++;
      $display("BAD %0t read %h got %h exp %h", $time, a, rdata, exp);
    end
  endtask : rd_reg

  task automatic chk(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk

  task automatic set_ctrl(input int kind);
    cw.kind = trig_qual_pkg::trig_kind_type'(kind);
    sel = kind;
    wr_reg(`OFS_CTRL, {17'h00000, cw});
  endtask : set_ctrl

  task automatic begin_win();
    @(posedge ref_clk);
    n_type = 0;
    n_trig = 0;
    counting <= 1'b1;
  endtask : begin_win

  task automatic end_win(input int exp, input string what);
    repeat (10) @(posedge ref_clk);
    counting <= 1'b0;
    @(posedge ref_clk);
    chk(n_type, exp, what);
    chk(n_trig, exp, what);
  endtask : end_win

  // Passes the midpoint so no runt or transition stays half armed
  task automatic settle(input logic [15:0] lvl);
    pulse_mv <= 16'h0096;
    repeat (6) @(posedge ref_clk);
    pulse_mv <= lvl;
    repeat (8) @(posedge ref_clk);
  endtask : settle

  function automatic int pw_exp(input int m, input int n);
    case (m)
      0: return int'(n >= LO);
      1: return int'(n > LO);
      2: return int'(n < LO);
      3: return int'(n >= LO - VAR && n <= LO + VAR);
      4: return int'(n < LO - VAR || n > LO + VAR);
      5: return int'(n > LO && n < UP);
      default: return int'(n < LO || n > UP);
    endcase
  endfunction : pw_exp

  function automatic int sl_exp(input int c, input int n);
    case (c)
      0: return int'(n > SREF);
      1: return int'(n < SREF);
      2: return int'(n >= SREF - SVAR && n <= SREF + SVAR);
      default: return int'(n < SREF - SVAR || n > SREF + SVAR);
    endcase
  endfunction : sl_exp

  initial begin
    #200_000;
    miscompares++;
    print_verdict();
  end

  initial begin
    cw = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    wr_reg(8'h40, 32'hFFFF_FFFF);
    foreach (ra[i]) rd_reg(ra[i], rv[i]);
    wr_reg(`OFS_PAT_CARE, 32'hFFFF_FFFF);
    rd_reg(`OFS_PAT_CARE, 32'h000F_FFFF);
    wr_reg(`OFS_PAT_CARE, 32'h0000_0013);
    wr_reg(`OFS_PAT_LEVEL, 32'h0000_0011);
    for (int i = 0; i < 7; i++) begin
      cw.comb_or = e_or[i];
      cw.pat_false = e_f[i];
      set_ctrl(0);
      pat <= e_a[i];
      repeat (8) @(posedge ref_clk);
      begin_win();
      pat <= e_b[i];
      end_win(int'(e_x[i]), "edge pattern");
    end
    wr_reg(`OFS_PAT_CARE, 32'h0000_0001);
    wr_reg(`OFS_LOWER_LIM, LO);
    wr_reg(`OFS_UPPER_LIM, UP);
    wr_reg(`OFS_VARIATION, VAR);
    wr_reg(`OFS_TRIG_COUNT, 32'h0000_0000);
    wr_reg(`OFS_STATUS, 32'h0000_000F);
    cw.comb_or = 1'b0;
    cw.pat_false = 1'b0;
    cw.dur_on = 1'b1;
    for (int m = 0; m < 7; m++) begin
      for (int j = 0; j < 3; j++) begin
        cw.pmode = trig_qual_pkg::pat_mode_type'(m);
        set_ctrl(0);
        pat <= 20'h00000;
        repeat (8) @(posedge ref_clk);
        begin_win();
        pat <= 20'h00001;
        repeat (wl[j]) @(posedge ref_clk);
        pat <= 20'h00000;
        end_win(pw_exp(m, wl[j]), "pattern width");
        total += pw_exp(m, wl[j]);
      end
    end
    rd_reg(`OFS_TRIG_COUNT, total);
    rd_reg(`OFS_STATUS, 32'h0000_0001);
    wr_reg(`OFS_STATUS, 32'h0000_0001);
    rd_reg(`OFS_STATUS, 32'h0000_0000);
    for (int p = 0; p < 3; p++) begin
      for (int w = 0; w < 3; w++) begin
        cw.rpol = trig_qual_pkg::runt_pol_type'(p);
        set_ctrl(1);
        settle(w_s[w]);
        begin_win();
        pulse_mv <= w_m[w];
        repeat (6) @(posedge ref_clk);
        pulse_mv <= w_s[w];
        end_win(int'((w == 0 && p != 1) || (w == 1 && p != 0)), "runt");
      end
    end
    wr_reg(`OFS_SLEW_REF, SREF);
    wr_reg(`OFS_SLEW_VAR, SVAR);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 3; s++) begin
        for (int d = 0; d < 2; d++) begin
          for (int r = 0; r < 3; r++) begin
            cw.scmp = trig_qual_pkg::slew_cmp_type'(c);
            cw.slope = trig_qual_pkg::slope_type'(s);
            set_ctrl(2);
            settle(d ? HI_MV : 16'h0000);
            begin_win();
            for (int k = 1; k <= 300 / rt[r]; k++) begin
              pulse_mv <= d ? HI_MV - 16'(k * rt[r]) : 16'(k * rt[r]);
              @(posedge ref_clk);
            end
            pulse_mv <= d ? 16'h0000 : HI_MV;
            end_win(sl_exp(c, sl[r]) * int'(s == 2 || s == d), "slew");
          end
        end
      end
    end
    wr_reg(`OFS_TMO_TIME, 32'h0000_0005);
    for (int h = 0; h < 2; h++) begin
      cw.tmo_high = h[0];
      set_ctrl(3);
      tmo_mv <= h ? 16'h0000 : HI_MV;
      repeat (8) @(posedge ref_clk);
      begin_win();
      tmo_mv <= h ? HI_MV : 16'h0000;
      repeat (3) @(posedge ref_clk);
      tmo_mv <= h ? 16'h0000 : HI_MV;
      repeat (3) @(posedge ref_clk);
      tmo_mv <= h ? HI_MV : 16'h0000;
      repeat (7) @(posedge ref_clk);
      tmo_mv <= h ? 16'h0000 : HI_MV;
      end_win(1, "timeout");
    end
    print_verdict();
  end
endmodule : trig_qual_tb
